// ===== bench/mrb_host.sv
/* host controller model: drives the serial clock, pulls data low;
   assumes the bench resolves the data wire with a pull-up */
`default_nettype none
module mrb_host #(
   parameter logic [6:0] ADDR = 7'h40
)(
   // clock
   input wire logic mclk,
   // serial lines
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // ****************************************
   // bus cycles
   // ****************************************
   task automatic hp;
      repeat (4) @(posedge mclk);
   endtask
   // data moves a cycle after the clock falls, so no false start or stop
   task automatic bit_io(input logic b, output logic r);
      @(posedge mclk) sda_low <= !b;
      repeat (3) @(posedge mclk);
      scl <= 1'b1;
      repeat (2) @(posedge mclk);
      r = sda;
      repeat (2) @(posedge mclk);
      scl <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q, output logic r9);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(b9, r9);
   endtask
   task automatic start;
      @(posedge mclk) sda_low <= 1'b0;
      hp();
      scl <= 1'b1;
      hp();
      sda_low <= 1'b1;
      hp();
      scl <= 1'b0;
   endtask
   task automatic stop;
      @(posedge mclk) sda_low <= 1'b1;
      hp();
      scl <= 1'b1;
      hp();
      sda_low <= 1'b0;
      hp();
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic full, output logic ok);
      logic [7:0] q;
      logic n0, n1, n2, n3;
      n2 = 1'b0;
      n3 = 1'b0;
      start();
      xfer({ADDR, 1'b0}, 1'b1, q, n0);
      xfer(p, 1'b1, q, n1);
      if (full) begin
         xfer(d[15:8], 1'b1, q, n2);
         xfer(d[7:0], 1'b1, q, n3);
      end
      stop();
      ok = !(n0 | n1 | n2 | n3);
   endtask
   // acks the first byte, nacks the second
   task automatic rd(output logic [15:0] d);
      logic [7:0] q;
      logic r;
      start();
      xfer({ADDR, 1'b1}, 1'b1, q, r);
      xfer(8'hFF, 1'b0, d[15:8], r);
      xfer(8'hFF, 1'b1, d[7:0], r);
      stop();
   endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
/* self-checking bench for the monitor register bank;
   assumes the host model and a pull-up on the data wire */
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
$display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mrb_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] adc_shunt = 16'h0000;
   logic [15:0] adc_bus = 16'h0000;
   logic scl, sda_low, sda_out, sda_oe_n, ok;
   logic [15:0] v;
   mrb_conv_s conv_phase;
   int err_total = 0;
   int num_checks = 0;
   wire logic sda = !(sda_low | (!sda_oe_n & !sda_out));
   always #20 mclk = ~mclk;
   // short conversion times, distinct per code
   mrb_top #(.CONV_CYC({24'd116, 24'd108, 24'd100, 24'd92, 24'd84, 24'd76, 24'd68, 24'd60})) mrb_top_i (
      .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .adc_shunt(adc_shunt), .adc_bus(adc_bus), .conv_phase(conv_phase));
   mrb_host mrb_host_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
   // ****************************************
   // helpers
   // ****************************************
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      mrb_host_i.wr(p, d, 1'b1, ok);
      `CHK("ack", 1'b1, ok)
   endtask
   task automatic rchk(input logic [7:0] p, input logic [15:0] e);
      mrb_host_i.wr(p, 16'h0000, 1'b0, ok);
      mrb_host_i.rd(v);
      `CHK("reg", e, v)
   endtask
   task automatic meas(input logic b, input int e);
      int n;
      n = 0;
      for (int i = 0; i < 600 && (b ? conv_phase.bus_on : conv_phase.shunt_on); i++) @(posedge mclk);
      for (int i = 0; i < 600 && !(b ? conv_phase.bus_on : conv_phase.shunt_on); i++) @(posedge mclk);
      for (int i = 0; i < 600 && (b ? conv_phase.bus_on : conv_phase.shunt_on); i++) begin
         @(posedge mclk);
         n++;
      end
      `CHK("conv time", e, n)
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rchk(8'h00, 16'h4127);
      wr(8'h00, 16'h4120);
      for (int p = 1; p < 8; p++) rchk(8'(p), 16'h0000);
   endtask
   task automatic t_access;
      for (int p = 1; p < 5; p++) begin
         wr(8'(p), 16'hFFFF);
         rchk(8'(p), 16'h0000);
      end
      wr(8'h05, 16'hFFFF);
      rchk(8'h05, 16'h7FFF);
      wr(8'h07, 16'hA55A);
      rchk(8'h07, 16'hA55A);
      wr(8'h00, 16'h3F00);
      rchk(8'h00, 16'h4F00);
      wr(8'h00, 16'h8000);
      rchk(8'h00, 16'h4127);
      rchk(8'h07, 16'h0000);
   endtask
   // power-on settings convert both inputs; scaling zero keeps derived ones zero
   task automatic t_math;
      @(posedge mclk) adc_shunt <= 16'h0100;
      adc_bus <= 16'h0200;
      repeat (300) @(posedge mclk);
      rchk(8'h01, 16'h0100);
      rchk(8'h04, 16'h0000);
      rchk(8'h03, 16'h0000);
      wr(8'h05, 16'h0800);
      repeat (300) @(posedge mclk);
      rchk(8'h04, 16'h0100);
      rchk(8'h03, 16'h0010);
      rchk(8'h02, 16'h0200);
   endtask
   task automatic t_modes;
      logic sh, bs, late;
      for (int m = 0; m < 8; m++) begin
         wr(8'h00, 16'h4000 | 16'(m));
         sh = 1'b0;
         bs = 1'b0;
         late = 1'b0;
         repeat (150) begin
            @(posedge mclk);
            sh |= conv_phase.shunt_on;
            bs |= conv_phase.bus_on;
         end
         repeat (150) @(posedge mclk);
         repeat (130) begin
            @(posedge mclk);
            late |= |conv_phase;
         end
         `CHK("mode run", {m[0], m[1]}, {sh, bs})
         `CHK("mode cont", m[2] & (m[1] | m[0]), late)
      end
   endtask
   // one triggered round sets the ready flag; the read that shows it clears it
   task automatic t_ready;
      wr(8'h00, 16'h4003);
      repeat (150) @(posedge mclk);
      rchk(8'h06, 16'h0008);
      rchk(8'h06, 16'h0000);
      wr(8'h06, 16'hFC1F);
      rchk(8'h06, 16'hFC17);
   endtask
   task automatic t_times;
      wr(8'h00, 16'h419F);
      rchk(8'h00, 16'h419F);
      meas(1'b0, 84);
      meas(1'b1, 108);
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      t_reset();
      t_access();
      t_math();
      t_modes();
      t_ready();
      t_times();
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      end_sim();
   end
endmodule
`default_nettype wire

// ===== rtl/mrb_i2c_byte.sv
/*
 * two-wire serial byte engine: start/stop detection, byte receive with
 * acknowledge, byte transmit; assumes the serial clock is several times
 * slower than mclk so that sampled edges are at least four cycles apart
 */
`default_nettype none
module mrb_i2c_byte
   import mrb_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // to register bank
   output mrb_ev_s ev,
   input wire logic ack_ok,
   input wire logic tx_go,
   input wire logic [7:0] tx_byte
);
   logic [2:0] scl_ff, sda_ff;
   mrb_eng_e st_ff, nxt_st;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] sh_ff, nxt_sh;
   logic drv_ff, nxt_drv, ack_ff, nxt_ack;
   mrb_ev_s ev_ff, nxt_ev;
   logic scl_r, scl_f, start, stop;

   // ****************************************
   // edge and condition detection
   // ****************************************
   // stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
   assign scl_r = scl_ff[1] & ~scl_ff[2];
   assign scl_f = ~scl_ff[1] & scl_ff[2];
   assign start = scl_ff[1] & scl_ff[2] & ~sda_ff[1] & sda_ff[2];
   assign stop = scl_ff[1] & scl_ff[2] & sda_ff[1] & ~sda_ff[2];

   // ****************************************
   // byte sequencing
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_drv = drv_ff;
      nxt_ack = ack_ff;
      nxt_ev = '0;
      if (start) begin
         nxt_st = E_RX;
         nxt_cnt = 4'h0;
         nxt_drv = 1'b0;
         nxt_ev.start = 1'b1;
      end else if (stop) begin
         nxt_st = E_IDLE;
         nxt_drv = 1'b0;
         nxt_ev.stop = 1'b1;
      end else begin
         unique case (st_ff)
            E_IDLE: ;
            E_RX: if (scl_r) begin
               // msb arrives first
               nxt_sh = {sh_ff[6:0], sda_ff[1]};
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == 4'h7) begin
                  nxt_ev.byte_vld = 1'b1;
                  nxt_st = E_RACK;
               end
            end
            E_RACK: if (scl_f) begin
               if (cnt_ff == 4'h8) begin
                  nxt_drv = ack_ok;
                  nxt_cnt = 4'h9;
                  if (!ack_ok)
                     nxt_st = E_IDLE;
               end else if (tx_go) begin
                  nxt_st = E_TX;
                  nxt_sh = tx_byte;
                  nxt_drv = ~tx_byte[7];
                  nxt_cnt = 4'h1;
               end else begin
                  nxt_st = E_RX;
                  nxt_drv = 1'b0;
                  nxt_cnt = 4'h0;
               end
            end
            E_TX: if (scl_f) begin
               if (cnt_ff == 4'h8) begin
                  nxt_drv = 1'b0;
                  nxt_ack = 1'b0;
                  nxt_st = E_TACK;
               end else begin
                  nxt_sh = {sh_ff[6:0], 1'b1};
                  nxt_drv = ~sh_ff[6];
                  nxt_cnt = cnt_ff + 4'h1;
               end
            end
            E_TACK: if (scl_r) begin
               nxt_ack = ~sda_ff[1];
               nxt_ev.tx_next = ~sda_ff[1];
            end else if (scl_f) begin
               // a missing acknowledge ends the read
               nxt_st = ack_ff ? E_TX : E_IDLE;
               nxt_sh = tx_byte;
               nxt_drv = ack_ff & ~tx_byte[7];
               nxt_cnt = 4'h1;
            end
            default: nxt_st = E_IDLE;
         endcase
      end
      nxt_ev.data = nxt_sh;
   end

   always_ff @(posedge mclk) begin
      scl_ff <= {scl_ff[1:0], scl_in};
      sda_ff <= {sda_ff[1:0], sda_in};
      if (reset) begin
         st_ff <= E_IDLE;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         drv_ff <= 1'b0;
         ack_ff <= 1'b0;
         ev_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         drv_ff <= nxt_drv;
         ack_ff <= nxt_ack;
         ev_ff <= nxt_ev;
      end
   end

   assign ev = ev_ff;
   assign sda_out = 1'b0;
   assign sda_oe_n = ~drv_ff;
endmodule
`default_nettype wire

// ===== rtl/mrb_top.sv
/*
 * monitor register bank: pointer-addressed 16-bit registers over the
 * two-wire serial port, configuration decode and conversion sequencing;
 * assumes converter codes arrive on mclk and are valid when sampled
 */
`default_nettype none
`include "mrb_defines.svh"
// Function
// - registers 16 bits, sent as two bytes
// - pointer 00 control register, reset 4127
// - pointer 01 shunt result, read-only, zero
// - pointer 02 bus result, read-only, zero
// - pointer 03 power result, read-only, zero
// - pointer 04 current result, read-only, zero
// - pointer 05 scaling register, bits 14:0 read/write, bit 15 reads zero, zero
// - pointer 06 alert config plus ready flag
// - pointer 07 alert threshold, read/write, zero
// - zero scaling gives zero current, power
// - control reads change nothing
// - control write halts, then restarts conversion
// - bit 15 soft reset, self-clearing
// - bits 11:9 pick averaging count
// - bits 8:6 pick bus conversion time
// - bits 5:3 pick shunt conversion time
// - bits 2:0 pick operating mode
// - write is pointer then two bytes
// - most significant byte goes first
// - current is shunt times scaling, shifted right 11
module mrb_top
   import mrb_pkg::*;
#(
   parameter logic [6:0] SLV_ADDR = 7'h40,
   parameter int CUR_SHIFT = 11,
   parameter int PWR_SHIFT = 13,
   parameter logic [7:0][23:0] CONV_CYC = {`MRB_CYC(`MRB_CT7_US), `MRB_CYC(`MRB_CT6_US),
      `MRB_CYC(`MRB_CT5_US), `MRB_CYC(`MRB_CT4_US), `MRB_CYC(`MRB_CT3_US),
      `MRB_CYC(`MRB_CT2_US), `MRB_CYC(`MRB_CT1_US), `MRB_CYC(`MRB_CT0_US)}
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // converter
   input wire logic [15:0] adc_shunt,
   input wire logic [15:0] adc_bus,
   output mrb_conv_s conv_phase
);
   mrb_ev_s ev;
   mrb_txn_e txn_ff, nxt_txn;
   mrb_regs_s reg_ff, nxt_reg;
   logic [7:0] ptr_ff, nxt_ptr, wmsb_ff, nxt_wmsb;
   logic [15:0] rd_word_ff, nxt_rd_word, wdata;
   logic rd_lo_ff, nxt_rd_lo, ack_ok_ff, nxt_ack_ok, tx_go_ff, nxt_tx_go;
   logic halt_ff, nxt_halt, go_ff, nxt_go, wr_now;
   mrb_conv_e c_ff, nxt_c;
   logic [23:0] cnt_ff, nxt_cnt;
   logic [10:0] rnd_ff, nxt_rnd;
   logic signed [25:0] acc_sh_ff, nxt_acc_sh, acc_bs_ff, nxt_acc_bs;
   logic store, rend, en_sh, en_bs;
   logic [3:0] avg_sh;
   logic [15:0] sh_avg, bs_avg, cur_val, pwr_val;
   logic signed [31:0] cur_prod, pwr_prod, cur_shr, pwr_shr;
   mrb_conv_s conv_ff;

   mrb_i2c_byte u_byte (
      .mclk(mclk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_n(sda_oe_n),
      .ev(ev),
      .ack_ok(ack_ok_ff),
      .tx_go(tx_go_ff),
      .tx_byte(rd_lo_ff ? rd_word_ff[7:0] : rd_word_ff[15:8])
   );

   // ****************************************
   // read selection
   // ****************************************
   function automatic logic [15:0] rd_sel(input mrb_regs_s r, input logic [7:0] p);
      logic zcal;
      zcal = (r.cal == `MRB_ZERO_RST);
      case (p)
         `MRB_PTR_CFG: rd_sel = r.cfg;
         `MRB_PTR_SHV: rd_sel = r.shv;
         `MRB_PTR_BSV: rd_sel = r.bsv;
         `MRB_PTR_PWR: rd_sel = zcal ? `MRB_ZERO_RST : r.pwr;
         `MRB_PTR_CUR: rd_sel = zcal ? `MRB_ZERO_RST : r.cur;
         `MRB_PTR_CAL: rd_sel = r.cal;
         `MRB_PTR_MSK: rd_sel = r.msk;
         `MRB_PTR_LIM: rd_sel = r.lim;
         default: rd_sel = `MRB_ZERO_RST;
      endcase
   endfunction

   // ****************************************
   // transactions and registers
   // ****************************************
   assign wr_now = ev.byte_vld && (txn_ff == T_WLSB);
   assign wdata = {wmsb_ff, ev.data};

   always_comb begin
      nxt_txn = txn_ff;
      nxt_reg = reg_ff;
      nxt_ptr = ptr_ff;
      nxt_wmsb = wmsb_ff;
      nxt_rd_word = rd_word_ff;
      nxt_rd_lo = rd_lo_ff;
      nxt_ack_ok = ack_ok_ff;
      nxt_tx_go = tx_go_ff;
      nxt_halt = halt_ff;
      nxt_go = go_ff & halt_ff;
      if (ev.start || ev.stop) begin
         nxt_txn = T_ADDR;
         nxt_tx_go = 1'b0;
         // an aborted control write still releases the halt
         if (halt_ff) begin
            nxt_halt = 1'b0;
            nxt_go = 1'b1;
         end
      end else if (ev.tx_next) begin
         nxt_rd_lo = ~rd_lo_ff;
         if (rd_lo_ff)
            nxt_rd_word = rd_sel(reg_ff, ptr_ff);
      end else if (ev.byte_vld) begin
         nxt_ack_ok = 1'b1;
         unique case (txn_ff)
            T_ADDR: if (ev.data[7:1] == SLV_ADDR) begin
               nxt_tx_go = ev.data[0];
               nxt_txn = ev.data[0] ? T_RD : T_PTR;
               // snapshot keeps both bytes of one word coherent
               nxt_rd_word = rd_sel(reg_ff, ptr_ff);
               nxt_rd_lo = 1'b0;
               if (ev.data[0] && ptr_ff == `MRB_PTR_MSK)
                  nxt_reg.msk[`MRB_RDY_BIT] = 1'b0;
            end else begin
               nxt_ack_ok = 1'b0;
               nxt_txn = T_IGN;
            end
            T_PTR: begin
               nxt_ptr = ev.data;
               nxt_txn = T_WMSB;
            end
            T_WMSB: begin
               nxt_wmsb = ev.data;
               nxt_txn = T_WLSB;
               if (ptr_ff == `MRB_PTR_CFG)
                  nxt_halt = 1'b1;
            end
            T_WLSB: nxt_txn = T_WMSB;
            T_RD, T_IGN: ;
         endcase
      end
      if (wr_now) begin
         unique case (ptr_ff)
            `MRB_PTR_CFG: begin
               nxt_halt = 1'b0;
               nxt_go = 1'b1;
               nxt_reg.cfg = {1'b0, `MRB_CFG_FIX_VAL, wdata[`MRB_AVG_HI:0]};
               nxt_reg.msk[`MRB_RDY_BIT] = 1'b0;
            end
            `MRB_PTR_CAL: nxt_reg.cal = {1'b0, wdata[14:0]};
            `MRB_PTR_MSK: begin
               nxt_reg.msk = wdata;
               nxt_reg.msk[`MRB_RDY_BIT] = reg_ff.msk[`MRB_RDY_BIT];
            end
            `MRB_PTR_LIM: nxt_reg.lim = wdata;
            default: ; // results take no writes
         endcase
      end
      if (store) begin
         if (en_sh) begin
            nxt_reg.shv = sh_avg;
            nxt_reg.cur = cur_val;
         end
         if (en_bs)
            nxt_reg.bsv = bs_avg;
         nxt_reg.pwr = pwr_val;
         // hardware set beats any clear in the same cycle except a soft reset
         nxt_reg.msk[`MRB_RDY_BIT] = 1'b1;
      end
      if (wr_now && ptr_ff == `MRB_PTR_CFG && wdata[`MRB_CFG_SRST_BIT]) begin
         // self-clearing: the bit is never stored
         nxt_reg = '{`MRB_CFG_RST, `MRB_ZERO_RST, `MRB_ZERO_RST, `MRB_ZERO_RST,
            `MRB_ZERO_RST, `MRB_ZERO_RST, `MRB_ZERO_RST, `MRB_ZERO_RST};
         nxt_ptr = `MRB_PTR_CFG;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         txn_ff <= T_ADDR;
         reg_ff <= '{`MRB_CFG_RST, `MRB_ZERO_RST, `MRB_ZERO_RST, `MRB_ZERO_RST,
            `MRB_ZERO_RST, `MRB_ZERO_RST, `MRB_ZERO_RST, `MRB_ZERO_RST};
         ptr_ff <= `MRB_PTR_CFG;
         wmsb_ff <= 8'h00;
         rd_word_ff <= 16'h0000;
         rd_lo_ff <= 1'b0;
         ack_ok_ff <= 1'b0;
         tx_go_ff <= 1'b0;
         halt_ff <= 1'b0;
         go_ff <= 1'b1;
      end else begin
         txn_ff <= nxt_txn;
         reg_ff <= nxt_reg;
         ptr_ff <= nxt_ptr;
         wmsb_ff <= nxt_wmsb;
         rd_word_ff <= nxt_rd_word;
         rd_lo_ff <= nxt_rd_lo;
         ack_ok_ff <= nxt_ack_ok;
         tx_go_ff <= nxt_tx_go;
         halt_ff <= nxt_halt;
         go_ff <= nxt_go;
      end
   end

   // ****************************************
   // conversion sequencing
   // ****************************************
   assign en_sh = reg_ff.cfg[`MRB_MODE_LO];
   assign en_bs = reg_ff.cfg[`MRB_MODE_LO + 1];

   always_comb begin
      unique case (reg_ff.cfg[`MRB_AVG_HI:`MRB_AVG_LO])
         3'h0: avg_sh = 4'h0;
         3'h1: avg_sh = 4'h2;
         3'h2: avg_sh = 4'h4;
         3'h3: avg_sh = 4'h6;
         3'h4: avg_sh = 4'h7;
         3'h5: avg_sh = 4'h8;
         3'h6: avg_sh = 4'h9;
         3'h7: avg_sh = 4'hA;
      endcase
   end

   always_comb begin
      nxt_c = c_ff;
      nxt_cnt = cnt_ff + 24'h1;
      nxt_rnd = rnd_ff;
      nxt_acc_sh = acc_sh_ff;
      nxt_acc_bs = acc_bs_ff;
      rend = 1'b0;
      store = 1'b0;
      if (halt_ff || go_ff) begin
         // restart from scratch so no sample mixes old and new settings
         nxt_c = (!halt_ff && en_sh) ? C_SHUNT : (!halt_ff && en_bs) ? C_BUS : C_IDLE;
         nxt_cnt = 24'h0;
         nxt_rnd = 11'h0;
         nxt_acc_sh = 26'sh0;
         nxt_acc_bs = 26'sh0;
      end else begin
         unique case (c_ff)
            C_IDLE: nxt_cnt = 24'h0;
            C_SHUNT: if (cnt_ff == CONV_CYC[reg_ff.cfg[`MRB_SCT_HI:`MRB_SCT_LO]] - 24'h1) begin
               nxt_acc_sh = acc_sh_ff + 26'($signed(adc_shunt));
               nxt_cnt = 24'h0;
               nxt_c = en_bs ? C_BUS : c_ff;
               rend = ~en_bs;
            end
            C_BUS: if (cnt_ff == CONV_CYC[reg_ff.cfg[`MRB_BCT_HI:`MRB_BCT_LO]] - 24'h1) begin
               nxt_acc_bs = acc_bs_ff + $signed({10'h000, adc_bus});
               nxt_cnt = 24'h0;
               rend = 1'b1;
            end
            default: nxt_c = C_IDLE;
         endcase
         if (rend) begin
            nxt_c = en_sh ? C_SHUNT : C_BUS;
            if (rnd_ff == (11'h1 << avg_sh) - 11'h1) begin
               store = 1'b1;
               nxt_rnd = 11'h0;
               nxt_acc_sh = 26'sh0;
               nxt_acc_bs = 26'sh0;
               // triggered modes stop after one averaged result
               if (!reg_ff.cfg[`MRB_MODE_HI])
                  nxt_c = C_IDLE;
            end else begin
               nxt_rnd = rnd_ff + 11'h1;
            end
         end
      end
   end

   // averages use the sum including this round's sample
   assign sh_avg = 16'((acc_sh_ff + ((c_ff == C_SHUNT) ? 26'($signed(adc_shunt)) : 26'sh0)) >>> avg_sh);
   assign bs_avg = 16'((acc_bs_ff + ((c_ff == C_BUS) ? $signed({10'h000, adc_bus}) : 26'sh0)) >>> avg_sh);
   assign cur_prod = $signed(sh_avg) * $signed({1'b0, reg_ff.cal[14:0]});
   assign cur_shr = cur_prod >>> CUR_SHIFT;
   assign cur_val = en_sh ? cur_shr[15:0] : reg_ff.cur;
   assign pwr_prod = $signed(cur_val) * $signed({1'b0, (en_bs ? bs_avg[14:0] : reg_ff.bsv[14:0])});
   assign pwr_shr = pwr_prod >>> PWR_SHIFT;
   assign pwr_val = pwr_shr[15:0];

   always_ff @(posedge mclk) begin
      if (reset) begin
         c_ff <= C_IDLE;
         cnt_ff <= 24'h0;
         rnd_ff <= 11'h0;
         acc_sh_ff <= 26'sh0;
         acc_bs_ff <= 26'sh0;
         conv_ff <= '0;
      end else begin
         c_ff <= nxt_c;
         cnt_ff <= nxt_cnt;
         rnd_ff <= nxt_rnd;
         acc_sh_ff <= nxt_acc_sh;
         acc_bs_ff <= nxt_acc_bs;
         conv_ff <= '{nxt_c == C_SHUNT, nxt_c == C_BUS};
      end
   end

   assign conv_phase = conv_ff;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_cfg_fixed_bits: assert property (reg_ff.cfg[14:12] == 3'h4 && !reg_ff.cfg[15])
      else $error("control bits 15:12 wrong");
   a_soft_reset_all: assert property (wr_now && ptr_ff == 8'h00 && wdata[15] |=>
      reg_ff.cfg == 16'h4127 && reg_ff.cal == 16'h0000 && reg_ff.lim == 16'h0000)
      else $error("soft reset did not restore defaults");
   a_cfg_write_halt: assert property (ev.byte_vld && txn_ff == T_WMSB && ptr_ff == 8'h00 |=>
      halt_ff ##1 c_ff == C_IDLE)
      else $error("control write did not halt conversion");
   a_cfg_restart: assert property (wr_now && ptr_ff == 8'h00 && !wdata[15] && wdata[1:0] != 2'h0 |->
      ##2 c_ff != C_IDLE)
      else $error("conversion did not restart");
   a_ro_unchanged: assert property (wr_now && ptr_ff == 8'h02 && !store |=> $stable(reg_ff.bsv))
      else $error("result register took a write");
   a_zero_cal_read: assert property ($rose(tx_go_ff) && reg_ff.cal == 16'h0000 &&
      (ptr_ff == 8'h03 || ptr_ff == 8'h04) |-> rd_word_ff == 16'h0000)
      else $error("current or power nonzero with zero scaling");
   a_read_no_effect: assert property (txn_ff == T_RD && ev.tx_next && !store |=> $stable(reg_ff.cfg))
      else $error("read altered control register");
   a_cal_store: assert property (wr_now && ptr_ff == 8'h05 && !wdata[15] |=> reg_ff.cal == $past(wdata))
      else $error("scaling write lost");
   a_msb_first: assert property (txn_ff == T_RD && $rose(tx_go_ff) |-> !rd_lo_ff)
      else $error("read did not begin with high byte");
   a_ready_flag: assert property (store |=> reg_ff.msk[3])
      else $error("ready flag not set");

   c_cfg_write: cover property (wr_now && ptr_ff == 8'h00);
   c_reg_read: cover property (txn_ff == T_RD && ev.tx_next ##[1:400] ev.tx_next);
   c_result_store: cover property (store && reg_ff.cal != 16'h0000);
endmodule
`default_nettype wire

// ===== shared/mrb_defines.svh
/*
 * register offsets, field positions, reset values and conversion timing
 * for the monitor register bank; assumes a 25 MHz block clock
 */
`ifndef MRB_DEFINES_SVH
`define MRB_DEFINES_SVH
// ****************************************
// register pointers
// ****************************************
`define MRB_PTR_CFG 8'h00
`define MRB_PTR_SHV 8'h01
`define MRB_PTR_BSV 8'h02
`define MRB_PTR_PWR 8'h03
`define MRB_PTR_CUR 8'h04
`define MRB_PTR_CAL 8'h05
`define MRB_PTR_MSK 8'h06
`define MRB_PTR_LIM 8'h07
// ****************************************
// reset values and fields
// ****************************************
`define MRB_CFG_RST 16'h4127
`define MRB_ZERO_RST 16'h0000
`define MRB_CFG_SRST_BIT 15
`define MRB_CFG_FIX_HI 14
`define MRB_CFG_FIX_LO 12
`define MRB_CFG_FIX_VAL 3'h4
`define MRB_AVG_HI 11
`define MRB_AVG_LO 9
`define MRB_BCT_HI 8
`define MRB_BCT_LO 6
`define MRB_SCT_HI 5
`define MRB_SCT_LO 3
`define MRB_MODE_HI 2
`define MRB_MODE_LO 0
`define MRB_RDY_BIT 3
// ****************************************
// conversion times in microseconds
// ****************************************
`define MRB_CLK_MHZ 25
`define MRB_CT0_US 140
`define MRB_CT1_US 204
`define MRB_CT2_US 332
`define MRB_CT3_US 588
`define MRB_CT4_US 1100
`define MRB_CT5_US 2116
`define MRB_CT6_US 4156
`define MRB_CT7_US 8244
`define MRB_CYC(us) (24'((us) * `MRB_CLK_MHZ))
`endif

// ===== shared/mrb_pkg.sv
/*
 * types shared by the register bank and its serial byte engine;
 * assumes nothing beyond a SystemVerilog compiler
 */
`default_nettype none
package mrb_pkg;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic start;
      logic stop;
      logic byte_vld;
      logic tx_next;
      logic [7:0] data;
   } mrb_ev_s;
   typedef struct packed {
      logic shunt_on;
      logic bus_on;
   } mrb_conv_s;
   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] shv;
      logic [15:0] bsv;
      logic [15:0] pwr;
      logic [15:0] cur;
      logic [15:0] cal;
      logic [15:0] msk;
      logic [15:0] lim;
   } mrb_regs_s;
   // ****************************************
   // states
   // ****************************************
   typedef enum logic [2:0] {E_IDLE, E_RX, E_RACK, E_TX, E_TACK} mrb_eng_e;
   typedef enum logic [2:0] {T_ADDR, T_PTR, T_WMSB, T_WLSB, T_RD, T_IGN} mrb_txn_e;
   typedef enum logic [1:0] {C_IDLE, C_SHUNT, C_BUS} mrb_conv_e;
endpackage
`default_nettype wire
